// >>> hw/motor_closed_loop_config.sv
// closed-loop speed pulse, enables and motor stop logic
// Operation
// R1 - The speed pulse output is divided by the 4-bit divider field, codes 0 and 1 by one, n by n.
// R2 - Window bit 0 keeps the speed pulse active while driven; 1 keeps it until back-EMF is low.
// R3 - The 3-bit cutoff field picks 1, 2, 5, 10, 20 or 30 mV; codes 6 and 7 are reserved.
// R4 - The surge protection runs exactly when its enable bit is 1.
// R5 - Deadtime compensation is applied only while its enable bit is 1.
// R6 - The velocity loop runs when its disable bit is 0 and is bypassed when it is 1.
// R7 - On a stop, code 0 floats the outputs, 2 brakes the low side, 4 spins down actively.
// R8 - Brake time on a stop is 1 ms for codes 0 to 4, then 5 ms up to 15000 ms for codes 5 to F.
// R9 - Active spin-down ends when speed falls under the threshold given as a share of top speed.
// R10 - The loop deceleration rate is used only with surge protection off and source bit 0.
`timescale 1ns/1ns
`include "motor_cl_params.svh"

module motor_closed_loop_config #(
    parameter int CYCLES_PER_MS = `CLK_HZ / `MS_PER_S
) (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    output logic      [31:0] reg_rdata,
    input  wire logic        motor_driven,
    input  wire logic        rotor_pulse,
    input  wire logic [7:0]  emf_mv,
    input  wire logic [7:0]  speed_half_pct,
    input  wire logic        stop_request,
    output logic             speed_pulse_output,
    output logic             surge_protection_active,
    output logic             deadtime_comp_active,
    output logic             velocity_loop_active,
    output logic             decel_from_loop_rate,
    output logic      [4:0]  loop_deceleration_rate,
    output logic             phase_hiz,
    output logic             low_side_brake,
    output logic             spin_down_active,
    output logic             stop_done
);

    if (CYCLES_PER_MS < 1 || CYCLES_PER_MS > 131072)
        $error("CYCLES_PER_MS must lie between 1 and 131072");

    // ----------------------------------------
    // decode functions
    // ----------------------------------------
    function automatic logic [7:0] emf_limit(input logic [2:0] code);
        case (code)
            3'h0:    emf_limit = 8'h01;
            3'h1:    emf_limit = 8'h02;
            3'h2:    emf_limit = 8'h05;
            3'h3:    emf_limit = 8'h0a;
            3'h4:    emf_limit = 8'h14;
            default: emf_limit = 8'h1e; // reserved codes act as the highest cutoff, 30 mV
        endcase
    endfunction : emf_limit
    function automatic logic [13:0] brake_ms(input logic [3:0] code);
        case (code)
            4'h5:    brake_ms = 14'h0005;
            4'h6:    brake_ms = 14'h000a;
            4'h7:    brake_ms = 14'h0032;
            4'h8:    brake_ms = 14'h0064;
            4'h9:    brake_ms = 14'h00fa;
            4'ha:    brake_ms = 14'h01f4;
            4'hb:    brake_ms = 14'h03e8;
            4'hc:    brake_ms = 14'h09c4;
            4'hd:    brake_ms = 14'h1388;
            4'he:    brake_ms = 14'h2710;
            4'hf:    brake_ms = 14'h3a98;
            default: brake_ms = 14'h0001;
        endcase
    endfunction : brake_ms
    // threshold in units of half a percent of top speed
    function automatic logic [7:0] spin_limit(input logic [3:0] code);
        case (code)
            4'h0:    spin_limit = 8'hc8;
            4'h1:    spin_limit = 8'hb4;
            4'h2:    spin_limit = 8'ha0;
            4'h3:    spin_limit = 8'h8c;
            4'h4:    spin_limit = 8'h78;
            4'h5:    spin_limit = 8'h64;
            4'h6:    spin_limit = 8'h5a;
            4'h7:    spin_limit = 8'h50;
            4'h8:    spin_limit = 8'h46;
            4'h9:    spin_limit = 8'h3c;
            4'ha:    spin_limit = 8'h32;
            4'hb:    spin_limit = 8'h28;
            4'hc:    spin_limit = 8'h1e;
            4'hd:    spin_limit = 8'h14;
            4'he:    spin_limit = 8'h0a;
            default: spin_limit = 8'h05;
        endcase
    endfunction : spin_limit

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [31:0] pulse_cfg;
    logic [31:0] stop_cfg;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pulse_cfg <= `REG_RESET;
            stop_cfg  <= `REG_RESET;
        end
        else if (reg_wr)
        begin
            if (reg_addr == `REG_OFS_SPEED_PULSE)
                pulse_cfg <= reg_wdata & `REG_MASK_SPEED_PULSE;
            if (reg_addr == `REG_OFS_STOP)
                stop_cfg <= reg_wdata & `REG_MASK_STOP;
        end
    end
    // unmapped offsets and reserved bits read as zero
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            reg_rdata <= `REG_RESET;
        else if (reg_rd)
        begin
            case (reg_addr)
                `REG_OFS_SPEED_PULSE: reg_rdata <= pulse_cfg;
                `REG_OFS_STOP:        reg_rdata <= stop_cfg;
                default:              reg_rdata <= `REG_RESET;
            endcase
        end
    end

    // ----------------------------------------
    // enables
    // ----------------------------------------
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            surge_protection_active <= 1'b0;
            deadtime_comp_active    <= 1'b0;
            velocity_loop_active    <= 1'b1;
            decel_from_loop_rate    <= 1'b1;
            loop_deceleration_rate  <= 5'h00;
        end
        else
        begin
            surge_protection_active <= pulse_cfg[`F_SURGE]; // R4
            deadtime_comp_active    <= pulse_cfg[`F_DEADTIME]; // R5
            velocity_loop_active    <= !pulse_cfg[`F_VLOOP_DIS]; // R6
            decel_from_loop_rate    <= !pulse_cfg[`F_SURGE] && !pulse_cfg[`F_DEC_SRC]; // R10
            loop_deceleration_rate  <= pulse_cfg[`F_DEC_RATE_HI:`F_DEC_RATE_LO]; // R10
        end
    end

    // ----------------------------------------
    // speed pulse divider
    // ----------------------------------------
    logic [3:0] div_n;
    logic [3:0] edge_count;
    logic       rotor_prev;
    logic       pulse_window;
    logic       pulse_state;
    assign div_n = (pulse_cfg[`F_DIV_HI:`F_DIV_LO] < 4'h2) ? 4'h1 : pulse_cfg[`F_DIV_HI:`F_DIV_LO]; // R1
    // coasting keeps the pulse alive only while back-EMF still clears the cutoff
    assign pulse_window = motor_driven ||
        (pulse_cfg[`F_WINDOW] && emf_mv >= emf_limit(pulse_cfg[`F_EMF_HI:`F_EMF_LO])); // R2 R3
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rotor_prev  <= 1'b0;
            edge_count  <= 4'h0;
            pulse_state <= 1'b0;
            speed_pulse_output <= 1'b0;
        end
        else
        begin
            rotor_prev <= rotor_pulse;
            if (!pulse_window)
                edge_count <= 4'h0;
            else if (rotor_pulse != rotor_prev)
            begin
                // each input edge counted; n edges make one output edge, so frequency / n
                if (edge_count + 4'h1 >= div_n) // R1
                begin
                    edge_count  <= 4'h0;
                    pulse_state <= !pulse_state;
                end
                else
                    edge_count <= edge_count + 4'h1;
            end
            speed_pulse_output <= pulse_window & pulse_state; // R2
        end
    end

    // ----------------------------------------
    // motor stop sequence
    // ----------------------------------------
    motor_cl_pkg::stop_state_t state;
    logic [16:0] ms_prescale;
    logic [13:0] ms_left;
    logic        ms_tick;
    assign ms_tick = (ms_prescale == 17'(CYCLES_PER_MS - 1));
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            ms_prescale <= 17'h00000;
        else if (state != motor_cl_pkg::ST_BRAKE || ms_tick)
            ms_prescale <= 17'h00000;
        else
            ms_prescale <= ms_prescale + 17'h00001;
    end
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state            <= motor_cl_pkg::ST_IDLE;
            ms_left          <= 14'h0000;
            phase_hiz        <= 1'b0;
            low_side_brake   <= 1'b0;
            spin_down_active <= 1'b0;
            stop_done        <= 1'b0;
        end
        else
        begin
            case (state)
                motor_cl_pkg::ST_IDLE:
                begin
                    stop_done <= 1'b0;
                    if (stop_request)
                    begin
                        case (stop_cfg[`F_STOP_HI:`F_STOP_LO]) // R7
                            `STOP_LOW_BRAKE:
                            begin
                                state          <= motor_cl_pkg::ST_BRAKE;
                                low_side_brake <= 1'b1;
                                ms_left <= brake_ms(stop_cfg[`F_BRAKE_HI:`F_BRAKE_LO]); // R8
                            end
                            `STOP_SPIN_DOWN:
                            begin
                                state            <= motor_cl_pkg::ST_SPIN;
                                spin_down_active <= 1'b1;
                            end
                            // reserved codes fall back to the safe floating stop
                            default:
                            begin
                                state     <= motor_cl_pkg::ST_HIZ;
                                phase_hiz <= 1'b1;
                            end
                        endcase
                    end
                end
                motor_cl_pkg::ST_HIZ:
                begin
                    state     <= motor_cl_pkg::ST_HOLD;
                    stop_done <= 1'b1;
                end
                motor_cl_pkg::ST_BRAKE:
                begin
                    if (ms_tick)
                    begin
                        if (ms_left == 14'h0001) // R8
                        begin
                            state          <= motor_cl_pkg::ST_HOLD;
                            low_side_brake <= 1'b0;
                            phase_hiz      <= 1'b1;
                            stop_done      <= 1'b1;
                        end
                        ms_left <= ms_left - 14'h0001;
                    end
                end
                motor_cl_pkg::ST_SPIN:
                begin
                    if (speed_half_pct < spin_limit(stop_cfg[`F_SPIN_HI:`F_SPIN_LO])) // R9
                    begin
                        state            <= motor_cl_pkg::ST_HOLD;
                        spin_down_active <= 1'b0;
                        phase_hiz        <= 1'b1;
                        stop_done        <= 1'b1;
                    end
                end
                motor_cl_pkg::ST_HOLD:
                begin
                    if (!stop_request)
                    begin
                        state     <= motor_cl_pkg::ST_IDLE;
                        phase_hiz <= 1'b0;
                        stop_done <= 1'b0;
                    end
                end
                default:
                    state <= motor_cl_pkg::ST_IDLE;
            endcase
        end
    end

endmodule : motor_closed_loop_config

// >>> shared/motor_cl_params.svh
// constants for the closed-loop configuration block
`ifndef MOTOR_CL_PARAMS_SVH
`define MOTOR_CL_PARAMS_SVH

// ----------------------------------------
// register offsets and reset values
// ----------------------------------------
`define REG_OFS_SPEED_PULSE  8'h88
`define REG_OFS_STOP         8'h8a
`define REG_RESET            32'h0000_0000
`define REG_MASK_SPEED_PULSE 32'h01f8_0ffe
`define REG_MASK_STOP        32'h7ff0_0000

// ----------------------------------------
// speed pulse and enables register fields
// ----------------------------------------
`define F_DEC_SRC            24
`define F_DEC_RATE_HI        23
`define F_DEC_RATE_LO        19
`define F_DIV_HI             11
`define F_DIV_LO             8
`define F_WINDOW             7
`define F_EMF_HI             6
`define F_EMF_LO             4
`define F_SURGE              3
`define F_DEADTIME           2
`define F_VLOOP_DIS          1

// ----------------------------------------
// stop register fields and codes
// ----------------------------------------
`define F_STOP_HI            30
`define F_STOP_LO            28
`define F_BRAKE_HI           27
`define F_BRAKE_LO           24
`define F_SPIN_HI            23
`define F_SPIN_LO            20
`define STOP_HIZ             3'h0
`define STOP_LOW_BRAKE       3'h2
`define STOP_SPIN_DOWN       3'h4

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_HZ               100000000
`define MS_PER_S             1000

`endif

// >>> shared/motor_cl_pkg.sv
// types shared by the closed-loop configuration block
package motor_cl_pkg;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_HIZ   = 3'b001,
        ST_BRAKE = 3'b010,
        ST_SPIN  = 3'b011,
        ST_HOLD  = 3'b100
    } stop_state_t;
endpackage : motor_cl_pkg

// >>> testbench/motor_cl_properties.sv
// concurrent checks on the closed-loop configuration ports
`timescale 1ns/1ns
module motor_cl_properties #(parameter int CYCLES_PER_MS = 4) (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic        motor_driven,
    input wire logic        rotor_pulse,
    input wire logic [7:0]  emf_mv,
    input wire logic [7:0]  speed_half_pct,
    input wire logic        stop_request,
    input wire logic        speed_pulse_output,
    input wire logic        surge_protection_active,
    input wire logic        deadtime_comp_active,
    input wire logic        velocity_loop_active,
    input wire logic        decel_from_loop_rate,
    input wire logic [4:0]  loop_deceleration_rate,
    input wire logic        phase_hiz,
    input wire logic        low_side_brake,
    input wire logic        spin_down_active,
    input wire logic        stop_done
);
    localparam int BMS[16] = '{1,1,1,1,1,5,10,50,100,250,500,1000,2500,5000,10000,15000};
    localparam int THR[16] = '{200,180,160,140,120,100,90,80,70,60,50,40,30,20,10,5};
    localparam int CUT[8] = '{1,2,5,10,20,30,30,30};
    logic [31:0] r88, r8a, bcnt, blen;
    logic        req_d;
    wire wr88 = reg_wr && reg_addr == 8'h88;
    wire win_shut = !motor_driven && !(r88[7] && emf_mv >= CUT[r88[6:4]]);
    // ----------------------------------------
    // shadow registers and brake counter
    // ----------------------------------------
    always_ff @(posedge clk or negedge resetn)
        if (!resetn)
        begin
            r88 <= '0;
            r8a <= '0;
            bcnt <= '0;
            blen <= '0;
            req_d <= 1'b0;
        end
        else
        begin
            if (wr88)
                r88 <= reg_wdata;
            if (reg_wr && reg_addr == 8'h8a)
                r8a <= reg_wdata;
            bcnt <= low_side_brake ? bcnt + 32'h1 : '0;
            req_d <= stop_request;
            // brake time is captured when the stop starts
            if (stop_request && !req_d)
                blen <= BMS[r8a[27:24]] * CYCLES_PER_MS;
        end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_surge; wr88 |-> ##2 surge_protection_active == $past(reg_wdata[3], 2); endproperty
    a_surge: assert property (p_surge) else $error("surge enable wrong");
    property p_dead; wr88 |-> ##2 deadtime_comp_active == $past(reg_wdata[2], 2); endproperty
    a_dead: assert property (p_dead) else $error("deadtime enable wrong");
    property p_vloop; wr88 |-> ##2 velocity_loop_active != $past(reg_wdata[1], 2); endproperty
    a_vloop: assert property (p_vloop) else $error("velocity loop wrong");
    property p_decel; wr88 |-> ##2 loop_deceleration_rate == $past(reg_wdata[23:19], 2)
        && decel_from_loop_rate == !($past(reg_wdata[3], 2) || $past(reg_wdata[24], 2)); endproperty
    a_decel: assert property (p_decel) else $error("deceleration wrong");
    property p_window; win_shut [*2] |-> !speed_pulse_output; endproperty
    a_window: assert property (p_window) else $error("pulse outside window");
    property p_hiz; $rose(stop_request) && r8a[30:28] != 3'h2 && r8a[30:28] != 3'h4
        |=> phase_hiz ##1 stop_done; endproperty
    a_hiz: assert property (p_hiz) else $error("float stop wrong");
    property p_brake; $fell(low_side_brake) |-> bcnt >= blen && bcnt <= blen + 2; endproperty
    a_brake: assert property (p_brake) else $error("brake length wrong");
    property p_spin; spin_down_active && speed_half_pct < THR[r8a[23:20]]
        |-> ##[1:2] !spin_down_active && phase_hiz; endproperty
    a_spin: assert property (p_spin) else $error("spin-down end wrong");
    c_brake: cover property ($fell(low_side_brake));
    c_spin: cover property ($fell(spin_down_active));
    c_pulse: cover property ($rose(speed_pulse_output));
endmodule : motor_cl_properties

// >>> testbench/motor_closed_loop_config_tb.sv
// self-checking bench for the closed-loop configuration block
`timescale 1ns/1ns
module motor_closed_loop_config_tb;
    logic clk, resetn, reg_wr, reg_rd, motor_driven, stop_request, run;
    logic [7:0] reg_addr, emf_set;
    logic [31:0] reg_wdata;
    wire logic [31:0] reg_rdata;
    wire logic rotor_pulse, speed_pulse_output, surge_protection_active, deadtime_comp_active;
    wire logic velocity_loop_active, decel_from_loop_rate, phase_hiz, low_side_brake;
    wire logic spin_down_active, stop_done;
    wire logic [4:0] loop_deceleration_rate;
    wire logic [7:0] emf_mv, speed_half_pct;
    int num_errors = 0, checks_done = 0, n, e;
    logic [40:0] rows[6] = '{{32'h8, 9'h140}, {32'h4, 9'h0e0}, {32'h2, 9'h020},
        {32'hf8_0000, 9'h07f}, {32'h108_0000, 9'h041}, {32'hffff_ffff, 9'h19f}};
    localparam int CUT[8] = '{1, 2, 5, 10, 20, 30, 30, 30};
    localparam int DIVS[5] = '{0, 1, 2, 3, 15};
    motor_closed_loop_config #(.CYCLES_PER_MS(4)) u_motor_closed_loop_config (.*);
    motor_model u_motor_model (.clk(clk), .resetn(resetn), .run(run), .emf_set(emf_set),
        .slowing(spin_down_active | low_side_brake), .rotor_pulse(rotor_pulse),
        .emf_mv(emf_mv), .speed_half_pct(speed_half_pct));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ----------------------------------------
    // bus, compare and measuring tasks
    // ----------------------------------------
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        cmp(reg_rdata, x);
    endtask : rd
    task automatic edges(output int c);
        logic p;
        repeat (6) @(negedge clk);
        c = 0;
        p = speed_pulse_output;
        repeat (200)
        begin
            @(negedge clk);
            c += int'(speed_pulse_output !== p);
            p = speed_pulse_output;
        end
    endtask : edges
    task automatic stop(input logic [2:0] m, input logic [3:0] b, input int eb, input logic es);
        int bc, sc, k;
        bc = 0;
        sc = 0;
        wr(8'h8a, {1'b0, m, b, 4'h5, 20'h0});
        @(posedge clk);
        run <= 1'b0;
        stop_request <= 1'b1;
        for (k = 0; k < 400 && stop_done !== 1'b1; k++)
        begin
            @(negedge clk);
            bc += int'(low_side_brake === 1'b1);
            sc += int'(spin_down_active === 1'b1);
        end
        cmp(k < 400, 1);
        if (k == 400)
            results();
        cmp({phase_hiz, sc > 0}, {1'b1, es});
        cmp(bc >= eb && bc <= eb + 2, 1);
        if (es)
            cmp(speed_half_pct < 8'h64, 1);
        @(posedge clk);
        stop_request <= 1'b0;
        run <= 1'b1;
        repeat (2) @(negedge clk);
        cmp({stop_done, phase_hiz}, 0);
    endtask : stop
    task automatic results;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results
    initial
    begin
        {resetn, reg_wr, reg_rd, motor_driven, stop_request, reg_addr, reg_wdata} = '0;
        run = 1'b1;
        emf_set = 8'h00;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        cmp({surge_protection_active, deadtime_comp_active, velocity_loop_active,
            decel_from_loop_rate, speed_pulse_output, phase_hiz, low_side_brake,
            spin_down_active, stop_done, loop_deceleration_rate}, 32'h0c00);
        rd(8'h8a, 0);
        foreach (rows[i])
        begin
            wr(8'h88, rows[i][40:9]);
            repeat (3) @(negedge clk);
            cmp({surge_protection_active, deadtime_comp_active, velocity_loop_active,
                decel_from_loop_rate, loop_deceleration_rate}, rows[i][8:0]);
            rd(8'h88, rows[i][40:9] & 32'h01f8_0ffe);
        end
        wr(8'h8c, 0);
        rd(8'h8c, 0);
        rd(8'h88, 32'h01f8_0ffe);
        wr(8'h8a, 32'hffff_ffff);
        rd(8'h8a, 32'h7ff0_0000);
        $display("test registers done");
        @(posedge clk);
        motor_driven <= 1'b1;
        foreach (DIVS[k])
        begin
            wr(8'h88, 32'(DIVS[k]) << 8);
            edges(n);
            e = 100 / (DIVS[k] < 2 ? 1 : DIVS[k]);
            cmp(n >= e - 1 && n <= e + 1, 1);
        end
        $display("test divider done");
        @(posedge clk);
        motor_driven <= 1'b0;
        for (int c = 0; c < 8; c++)
        begin
            wr(8'h88, 32'h80 | 32'(c) << 4);
            emf_set <= 8'(CUT[c]);
            edges(n);
            cmp(n > 0, 1);
            @(posedge clk);
            emf_set <= 8'(CUT[c] - 1);
            edges(n);
            cmp(n, 0);
        end
        wr(8'h88, 0);
        emf_set <= 8'hff;
        edges(n);
        cmp(n, 0);
        $display("test window done");
        stop(3'h0, 4'h0, 0, 1'b0);
        stop(3'h2, 4'h5, 20, 1'b0);
        stop(3'h2, 4'h0, 4, 1'b0);
        stop(3'h4, 4'h0, 0, 1'b1);
        stop(3'h3, 4'hf, 0, 1'b0);
        stop(3'h7, 4'h0, 0, 1'b0);
        $display("test stop done");
        wr(8'h88, 32'h0000_000e);
        repeat (3) @(negedge clk);
        cmp({surge_protection_active, deadtime_comp_active, velocity_loop_active}, 3'h6);
        @(posedge clk);
        resetn <= 1'b0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        cmp({surge_protection_active, deadtime_comp_active, velocity_loop_active,
            decel_from_loop_rate, speed_pulse_output, phase_hiz, low_side_brake,
            spin_down_active, stop_done, loop_deceleration_rate}, 32'h0c00);
        rd(8'h88, 0);
        $display("test reset done");
        results();
    end
endmodule : motor_closed_loop_config_tb

bind motor_closed_loop_config motor_cl_properties #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_props (.*);

// >>> testbench/motor_model.sv
// behavioural motor with the speed sensor that feeds the block
`timescale 1ns/1ns
module motor_model (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       run,
    input  wire logic [7:0] emf_set,
    input  wire logic       slowing,
    output logic            rotor_pulse,
    output logic      [7:0] emf_mv,
    output logic      [7:0] speed_half_pct
);
    logic ph;
    assign emf_mv = emf_set;
    // sensor edge every second cycle so no edge falls between two samples
    always_ff @(posedge clk or negedge resetn)
        if (!resetn)
        begin
            ph <= 1'b0;
            rotor_pulse <= 1'b0;
            speed_half_pct <= 8'hc8;
        end
        else
        begin
            ph <= ~ph;
            if (ph)
                rotor_pulse <= ~rotor_pulse;
            if (run)
                speed_half_pct <= 8'hc8;
            else if (slowing && speed_half_pct != 8'h00)
                speed_half_pct <= speed_half_pct - 8'h01;
        end
endmodule : motor_model
